// ### rtl/fodrv_pkg.sv
// Types shared by the fail output block
package fodrv_pkg;
    typedef enum logic [2:0] {
        FODRV_NORMAL, FODRV_STOP, FODRV_SLEEP, FODRV_RESTART, FODRV_FAILSAFE
    } fodrv_mode_t;
    typedef enum logic [2:0] {
        FODRV_PIN_FAULT, FODRV_PIN_OFF, FODRV_PIN_WAKE, FODRV_PIN_LOW, FODRV_PIN_HIGH
    } fodrv_pin_t;
    typedef enum logic [1:0] {FODRV_AHB_IDLE, FODRV_AHB_RD, FODRV_AHB_WR} fodrv_ahb_t;
endpackage

// ### rtl/fodrv_regs.svh
// Register offsets, field positions, reset values and timing counts of the fail output block
`ifndef FODRV_REGS_SVH
`define FODRV_REGS_SVH
`define FODRV_CTRL_OFS        12'h000
`define FODRV_PINCFG_OFS      12'h004
`define FODRV_STATUS_OFS      12'h008
`define FODRV_WAKE_OFS        12'h00C
`define FODRV_LEVEL_OFS       12'h010
`define FODRV_EVENT_OFS       12'h014
`define FODRV_CTRL_FORCE_BIT  0
`define FODRV_CTRL_OVEN_BIT   1
`define FODRV_CTRL_CFG_LSB    2
`define FODRV_CTRL_DC_LSB     4
`define FODRV_CTRL_MODE_LSB   6
`define FODRV_CTRL_RST        32'h0000_0000
`define FODRV_PINCFG_RST      32'h0000_0000
`define FODRV_UV_LIMIT        3'h4
`define FODRV_CLK_HZ          250000000
`define FODRV_BLINK_MHZ       1250
`define FODRV_DIM_HZ          100
`define FODRV_BLINK_CYC       ((`FODRV_CLK_HZ / `FODRV_BLINK_MHZ) * 1000)
`define FODRV_DIM_CYC         (`FODRV_CLK_HZ / `FODRV_DIM_HZ)
`endif

// ### rtl/fodrv_top.sv
// Fail output logic with alternate pin functions and AHB-Lite register slave
`timescale 1ns/100ps
`include "fodrv_regs.svh"

module fodrv_top
    import fodrv_pkg::*;
#(
    parameter int BLINK_CYC = `FODRV_BLINK_CYC,
    parameter int DIM_CYC   = `FODRV_DIM_CYC
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Fault sources
    input  wire logic        wdog_fail_evt,
    input  wire logic        wdog_trig_ok,
    input  wire logic        wdog_stop_off,
    input  wire logic        thermal_shutdown_lvl2,
    input  wire logic        main_supply_out_short,
    input  wire logic        main_supply_out_ov,
    input  wire logic        main_supply_out_uv_evt,
    input  wire logic        main_supply_out_ok,
    // Pin inputs
    input  wire logic        blink_pin_in,
    input  wire logic        dim_out_test_pin_in,
    // Fail and alternate outputs, open-drain low drive plus high-side drive
    output logic             static_fault_out,
    output logic             static_fault_out_oe,
    output logic             blink_fault_out,
    output logic             blink_fault_out_oe,
    output logic             dim_fault_out,
    output logic             dim_fault_out_oe,
    // Mode request to the state machine
    output logic             failsafe_req,
    output logic             wake_evt
);

    // Whole state of the block in one record
    typedef struct packed {
        // Software registers
        logic [31:0] ctrl;
        logic [5:0]  pincfg;
        // Bus transfer in its data phase
        fodrv_ahb_t  ph;
        logic [11:0] addr;
        logic [31:0] rdata;
        // Fault bookkeeping
        logic        wdog_fault_flag;
        logic [1:0]  wd_cnt;
        logic [2:0]  uv_cnt;
        logic        failure;
        logic        failsafe;
        // Wake capture on the alternate pins
        logic [1:0]  wake_st;
        logic [1:0]  pin_prev;
        // Waveform counters and output enable
        logic [31:0] blink_cnt;
        logic [31:0] dim_cnt;
        logic        drive_on;
    } fodrv_state_t;

    fodrv_state_t st;
    fodrv_state_t next_st;

    fodrv_mode_t  mode;
    logic [1:0]   cfg;
    logic         cause;
    logic         wd_act;
    logic         ev_act;
    logic         blink_ph;
    logic         dim_ph;
    logic [31:0]  dim_high;
    logic [31:0]  wdata;
    logic [1:0]   pin_lvl;
    logic [1:0]   wake_en;

    assign mode    = fodrv_mode_t'(st.ctrl[`FODRV_CTRL_MODE_LSB +: 3]);
    assign cfg     = st.ctrl[`FODRV_CTRL_CFG_LSB +: 2];
    assign pin_lvl = {dim_out_test_pin_in, blink_pin_in};
    assign wdata   = hwdata;

    // Duty selection of the dim output
    always_comb begin
        unique case (st.ctrl[`FODRV_CTRL_DC_LSB +: 2])
            2'h0: begin
                dim_high = DIM_CYC / 5;
            end
            2'h1: begin
                dim_high = DIM_CYC / 10;
            end
            2'h2: begin
                dim_high = DIM_CYC / 20;
            end
            2'h3: begin
                dim_high = DIM_CYC / 40;
            end
        endcase
    end

    // Waveform phases from counters
    assign blink_ph = st.blink_cnt < 32'(BLINK_CYC / 2);
    assign dim_ph   = st.dim_cnt < dim_high;

    // Pin function per pin, with mode gating
    function automatic fodrv_pin_t pin_fn(input logic [2:0] c, input fodrv_mode_t m);
        fodrv_pin_t f;
        f = fodrv_pin_t'(c);
        if (f == FODRV_PIN_OFF) begin
            pin_fn = FODRV_PIN_OFF;
        end else if (m == FODRV_FAILSAFE) begin
            pin_fn = FODRV_PIN_FAULT;
        end else if (m == FODRV_RESTART && f != FODRV_PIN_WAKE && f != FODRV_PIN_FAULT) begin
            pin_fn = FODRV_PIN_OFF;
        end else begin
            pin_fn = f;
        end
    endfunction

    fodrv_pin_t fn2;
    fodrv_pin_t fn3;
    assign fn2 = pin_fn(st.pincfg[2:0], mode);
    assign fn3 = pin_fn(st.pincfg[5:3], mode);
    assign wake_en = {fn3 == FODRV_PIN_WAKE, fn2 == FODRV_PIN_WAKE};

    // Next-state logic
    always_comb begin
        next_st = st;
        cause   = 1'b0;
        wd_act  = 1'b0;
        ev_act  = 1'b0;
        // Watchdog failure counting and fault flag
        if (wdog_fail_evt) begin
            next_st.wdog_fault_flag = 1'b1;
            if (st.wd_cnt != 2'h3) begin
                next_st.wd_cnt = st.wd_cnt + 2'h1;
            end
            if (cfg[1] ? (st.wd_cnt >= 2'h1) : 1'b1) begin
                wd_act = 1'b1;
            end
        end
        if (wdog_trig_ok) begin
            next_st.wdog_fault_flag = 1'b0;
            next_st.wd_cnt  = 2'h0;
        end
        // Undervoltage run counter
        if (main_supply_out_ok) begin
            next_st.uv_cnt = 3'h0;
        end
        if (main_supply_out_uv_evt && st.uv_cnt != `FODRV_UV_LIMIT) begin
            next_st.uv_cnt = st.uv_cnt + 3'h1;
        end
        // Non-watchdog fault causes
        cause = thermal_shutdown_lvl2 | main_supply_out_short
              | (main_supply_out_ov & st.ctrl[`FODRV_CTRL_OVEN_BIT])
              | (st.uv_cnt == `FODRV_UV_LIMIT);
        if (cause) begin
            ev_act           = 1'b1;
            next_st.failsafe = 1'b1;
            next_st.wdog_fault_flag  = 1'b0;
        end
        if (wd_act && cfg != 2'h1) begin
            next_st.failsafe = 1'b1;
        end
        if (mode == FODRV_SLEEP || (mode == FODRV_STOP && wdog_stop_off)) begin
            next_st.wdog_fault_flag = 1'b0;
        end
        if (mode == FODRV_NORMAL && !cause) begin
            next_st.failsafe = 1'b0;
        end
        // Blink and dim counters free running from the block clock
        next_st.blink_cnt = (st.blink_cnt >= 32'(BLINK_CYC - 1)) ? 32'h0000_0000
                          : st.blink_cnt + 32'h0000_0001;
        next_st.dim_cnt   = (st.dim_cnt >= 32'(DIM_CYC - 1)) ? 32'h0000_0000
                          : st.dim_cnt + 32'h0000_0001;
        // Wake edge capture, set wins over clear
        next_st.pin_prev = pin_lvl;
        // Bus data phase: idle defaults, then the pending write lands
        next_st.rdata = 32'h0000_0000;
        next_st.ph    = FODRV_AHB_IDLE;
        if (st.ph == FODRV_AHB_WR) begin
            unique case (st.addr)
                `FODRV_CTRL_OFS: begin
                    next_st.ctrl = wdata;
                end
                `FODRV_PINCFG_OFS: begin
                    if (mode == FODRV_NORMAL) begin
                        next_st.pincfg = wdata[5:0];
                    end
                end
                `FODRV_STATUS_OFS: begin
                    if (wdata[0] && !cause && !st.wdog_fault_flag) begin
                        next_st.failure = 1'b0;
                    end
                end
                `FODRV_WAKE_OFS: begin
                    next_st.wake_st = st.wake_st & ~wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Address phase taken: a read picks its word now, so the word stands
        // through the data phase; a write landing at this edge is seen already
        if (hsel && hready && htrans[1]) begin
            next_st.ph   = hwrite ? FODRV_AHB_WR : FODRV_AHB_RD;
            next_st.addr = {haddr[11:2], 2'b00};
            if (!hwrite) begin
                unique case ({haddr[11:2], 2'b00})
                    `FODRV_CTRL_OFS: begin
                        next_st.rdata = next_st.ctrl;
                    end
                    `FODRV_PINCFG_OFS: begin
                        next_st.rdata = {26'h000_0000, next_st.pincfg};
                    end
                    `FODRV_STATUS_OFS: begin
                        next_st.rdata = {29'h0000_0000, next_st.failsafe,
                                         next_st.wdog_fault_flag, next_st.failure};
                    end
                    `FODRV_WAKE_OFS: begin
                        next_st.rdata = {30'h0000_0000, next_st.wake_st};
                    end
                    `FODRV_LEVEL_OFS: begin
                        // Levels only visible in normal and stop modes
                        if (mode == FODRV_NORMAL || mode == FODRV_STOP) begin
                            next_st.rdata = {30'h0000_0000, pin_lvl};
                        end
                    end
                    `FODRV_EVENT_OFS: begin
                        next_st.rdata = {29'h0000_0000, next_st.uv_cnt};
                    end
                    default: begin
                        next_st.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Wake events on rising or falling pin level, set wins over clear
        for (int i = 0; i < 2; i++) begin
            if (wake_en[i] && (pin_lvl[i] != st.pin_prev[i])) begin
                next_st.wake_st[i] = 1'b1;
            end
        end
        // Fault flag set wins over clear
        if (ev_act || (wd_act && !(cfg == 2'h1 && st.wd_cnt == 2'h0))) begin
            next_st.failure = 1'b1;
        end
        // Outputs stay on through restart until the flag clears
        next_st.drive_on = next_st.failure | next_st.ctrl[`FODRV_CTRL_FORCE_BIT]
                         | (wd_act & cfg != 2'h1);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= '0;
            st.ctrl   <= `FODRV_CTRL_RST;
            st.pincfg <= 6'(`FODRV_PINCFG_RST);
            st.ph     <= FODRV_AHB_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Pin drive: low active fault outputs, alternates as switches
    always_comb begin
        static_fault_out    = 1'b0;
        static_fault_out_oe = st.drive_on;
        blink_fault_out     = 1'b0;
        blink_fault_out_oe  = 1'b0;
        dim_fault_out       = 1'b0;
        dim_fault_out_oe    = 1'b0;
        // Second pin: blinking fault output or switch
        unique case (fn2)
            FODRV_PIN_FAULT: begin
                blink_fault_out_oe = st.drive_on & blink_ph;
            end
            FODRV_PIN_LOW: begin
                blink_fault_out_oe = 1'b1;
            end
            FODRV_PIN_HIGH: begin
                blink_fault_out    = 1'b1;
                blink_fault_out_oe = 1'b1;
            end
            default: blink_fault_out_oe = 1'b0;
        endcase
        // Third pin: dimmed fault output or switch
        unique case (fn3)
            FODRV_PIN_FAULT: begin
                dim_fault_out_oe = st.drive_on & dim_ph;
            end
            FODRV_PIN_LOW: begin
                dim_fault_out_oe = 1'b1;
            end
            FODRV_PIN_HIGH: begin
                dim_fault_out    = 1'b1;
                dim_fault_out_oe = 1'b1;
            end
            default: dim_fault_out_oe = 1'b0;
        endcase
    end

    // Bus answers and side outputs
    assign hrdata       = st.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign failsafe_req = st.failsafe;
    assign wake_evt     = |st.wake_st;

endmodule

// ### test/fodrv_load_model.sv
// Lamp and external switch loads hanging on the second and third fail pins
`timescale 1ns/100ps
module fodrv_load_model (
    // Driver side of the pins
    input  wire logic blink_val,
    input  wire logic blink_oe,
    input  wire logic dim_val,
    input  wire logic dim_oe,
    // Level forced by the external switch while the pin is released
    input  wire logic ext_lvl,
    // Pin levels seen back by the block
    output logic      blink_lvl,
    output logic      dim_lvl
);
    // Lamp pull-up while released, so an idle fail pin reads high
    assign blink_lvl = blink_oe ? blink_val : 1'b1;
    // External switch drives the third pin when it acts as a wake input
    assign dim_lvl   = dim_oe ? dim_val : ext_lvl;
endmodule

// ### test/fodrv_top_bench.sv
// Directed register and fault tests of the fail output block
`timescale 1ns/100ps
`include "fodrv_regs.svh"
module fodrv_top_bench;
    localparam int BLINK = 200;
    localparam int DIM   = 400;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_lvl = 1'b1;
    logic        wfail = 1'b0, wok = 1'b0, wstop = 1'b0, uv = 1'b0, vok = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  src = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic        hready, hreadyout, hresp, sfo, sfo_oe, bfo, bfo_oe, dfo, dfo_oe;
    logic        bpin, dpin, failsafe_req, wake_evt;
    int          fails = 0, checked = 0, cyc = 0, nb, nd;
    wire logic   fon = sfo_oe & ~sfo;
    assign hready = hreadyout;
    fodrv_top #(.BLINK_CYC(BLINK), .DIM_CYC(DIM)) dut_u (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .wdog_fail_evt(wfail), .wdog_trig_ok(wok), .wdog_stop_off(wstop),
        .thermal_shutdown_lvl2(src[0]), .main_supply_out_short(src[1]),
        .main_supply_out_ov(src[2]), .main_supply_out_uv_evt(uv), .main_supply_out_ok(vok),
        .blink_pin_in(bpin), .dim_out_test_pin_in(dpin), .static_fault_out(sfo),
        .static_fault_out_oe(sfo_oe), .blink_fault_out(bfo), .blink_fault_out_oe(bfo_oe),
        .dim_fault_out(dfo), .dim_fault_out_oe(dfo_oe), .failsafe_req, .wake_evt);
    fodrv_load_model load_u (.blink_val(bfo), .blink_oe(bfo_oe), .dim_val(dfo),
        .dim_oe(dfo_oe), .ext_lvl, .blink_lvl(bpin), .dim_lvl(dpin));
    // Clock and hang guard
    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // One single AHB-Lite transfer, read data left in rd
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk("register", e, rd);
    endtask
    task automatic chk_st(input logic e);
        ahb(1'b0, `FODRV_STATUS_OFS, 32'h0000_0000);
        chk("failure", e, rd[0]);
    endtask
    task automatic clr();
        ahb(1'b1, `FODRV_STATUS_OFS, 32'h0000_0001);
        wt(6);
    endtask
    task automatic do_reset();
        @(posedge hclk) hresetn <= 1'b0;
        wt(3);
        hresetn <= 1'b1;
    endtask
    task automatic pulse_wd();
        @(posedge hclk) wfail <= 1'b1;
        @(posedge hclk) wfail <= 1'b0;
        wt(6);
    endtask
    // Count low-drive cycles of the blink and dim outputs
    task automatic meas(input int n);
        nb = 0;
        nd = 0;
        repeat (n) begin
            @(posedge hclk);
            nb += int'(bfo_oe === 1'b1 && bfo === 1'b0);
            nd += int'(dfo_oe === 1'b1 && dfo === 1'b0);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        wt(3);
        hresetn <= 1'b1;
        chk_reg(`FODRV_CTRL_OFS, `FODRV_CTRL_RST);
        chk_reg(`FODRV_PINCFG_OFS, `FODRV_PINCFG_RST);
        ahb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk_reg(12'h020, 32'h0000_0000);
        // Force bit, blink ratio and every dim duty
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0001);
        wt(2);
        chk("fault_on", 1'b1, fon);
        chk_st(1'b0);
        meas(BLINK);
        chk("blink_low", BLINK / 2, nb);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0001 | (i << 4));
            meas(DIM);
            chk("dim_low", (DIM / 5) >> i, nd);
        end
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0000);
        wt(2);
        chk("fault_off", 1'b0, fon);
        $display("test force done");
        // Overvoltage ignored without its enable
        @(posedge hclk) src <= 3'h4;
        wt(6);
        chk("ov_off", 1'b0, fon);
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0002);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk) src <= 3'h1 << i;
            wt(6);
            chk("fault_on", 1'b1, fon);
            chk("failsafe", 1'b1, failsafe_req);
            chk_st(1'b1);
            clr();
            @(posedge hclk) src <= 3'h0;
            wt(6);
            chk("held", 1'b1, fon);
            clr();
            chk("fault_off", 1'b0, fon);
        end
        $display("test causes done");
        // Undervoltage run broken by a good supply, then four in a row
        for (int i = 0; i < 6; i++) begin
            @(posedge hclk) uv <= 1'b1;
            @(posedge hclk) uv <= 1'b0;
            if (i == 2) begin
                @(posedge hclk) vok <= 1'b1;
                @(posedge hclk) vok <= 1'b0;
            end
        end
        wt(6);
        chk("uv_three", 1'b0, fon);
        @(posedge hclk) uv <= 1'b1;
        @(posedge hclk) uv <= 1'b0;
        wt(6);
        chk("uv_four", 1'b1, fon);
        @(posedge hclk) vok <= 1'b1;
        @(posedge hclk) vok <= 1'b0;
        clr();
        chk("fault_off", 1'b0, fon);
        $display("test undervoltage done");
        // Watchdog failures in every configuration
        for (int c = 0; c < 4; c++) begin
            do_reset();
            ahb(1'b1, `FODRV_CTRL_OFS, c << 2);
            pulse_wd();
            chk_st(c == 0);
            pulse_wd();
            if (c > 1)
                chk("wd_second", 1'b1, fon);
        end
        @(posedge hclk) wok <= 1'b1;
        @(posedge hclk) wok <= 1'b0;
        clr();
        chk("wd_off", 1'b0, fon);
        $display("test watchdog done");
        // Alternate pins, wake events and mode locking
        ahb(1'b1, `FODRV_PINCFG_OFS, 32'h0000_0014);
        wt(2);
        chk("high_side", 2'b11, {bfo_oe, bfo});
        chk_reg(`FODRV_LEVEL_OFS, 32'h0000_0003);
        @(posedge hclk) ext_lvl <= 1'b0;
        wt(6);
        chk("wake", 1'b1, wake_evt);
        ahb(1'b1, `FODRV_WAKE_OFS, 32'hFFFF_FFFF);
        wt(2);
        chk("wake_clr", 1'b0, wake_evt);
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0040);
        ahb(1'b1, `FODRV_PINCFG_OFS, 32'h0000_0000);
        chk_reg(`FODRV_PINCFG_OFS, 32'h0000_0014);
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_00C0);
        wt(2);
        chk("restart_hs", 1'b0, bfo_oe & bfo);
        ahb(1'b1, `FODRV_CTRL_OFS, 32'h0000_0100);
        wt(2);
        chk("safe_hs", 1'b0, bfo_oe & bfo);
        $display("test pins done");
        report_and_stop();
    end
endmodule

// ### test/fodrv_top_sva.sv
// Concurrent checks on the ports of the fail output block
`timescale 1ns/100ps
module fodrv_sva #(
    parameter int BLINK_CYC = 200,
    parameter int DIM_CYC   = 400
) (
    // Clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Fault causes and outputs
    input wire logic        thermal_shutdown_lvl2,
    input wire logic        main_supply_out_short,
    input wire logic        main_supply_out_uv_evt,
    input wire logic        main_supply_out_ok,
    input wire logic        static_fault_out,
    input wire logic        static_fault_out_oe,
    input wire logic        blink_fault_out,
    input wire logic        blink_fault_out_oe,
    input wire logic        failsafe_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] uv_run;
    // Run of undervoltage events since the supply was last good
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            uv_run <= 3'h0;
        else if (main_supply_out_ok)
            uv_run <= 3'h0;
        else if (main_supply_out_uv_evt && uv_run != 3'h7)
            uv_run <= uv_run + 3'h1;
    end
    property p_ready; hreadyout == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response given");
    property p_rd_idle;
        !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    property p_low_act; static_fault_out_oe |-> !static_fault_out; endproperty
    a_low_act: assert property (p_low_act) else $error("static output driven high");
    property p_thermal; $rose(thermal_shutdown_lvl2) |-> ##[1:4] static_fault_out_oe; endproperty
    a_thermal: assert property (p_thermal) else $error("thermal fault not shown");
    property p_short; $rose(main_supply_out_short) |-> ##[1:4] static_fault_out_oe; endproperty
    a_short: assert property (p_short) else $error("supply short not shown");
    property p_safe; thermal_shutdown_lvl2 [*2] |-> ##[0:3] failsafe_req; endproperty
    a_safe: assert property (p_safe) else $error("no fail-safe request");
    property p_hold;
        static_fault_out_oe && main_supply_out_short |=> static_fault_out_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("output released with cause present");
    property p_uv;
        main_supply_out_uv_evt && !main_supply_out_ok && uv_run == 3'h3
            |-> ##[1:4] static_fault_out_oe;
    endproperty
    a_uv: assert property (p_uv) else $error("fourth undervoltage not shown");
    c_on: cover property ($rose(static_fault_out_oe));
    c_blink: cover property (blink_fault_out_oe && !blink_fault_out);
    c_safe: cover property ($rose(failsafe_req));
endmodule
bind fodrv_top fodrv_sva #(.BLINK_CYC(BLINK_CYC), .DIM_CYC(DIM_CYC)) chk_u (.hclk, .hresetn,
    .hsel, .hready, .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .thermal_shutdown_lvl2,
    .main_supply_out_short, .main_supply_out_uv_evt, .main_supply_out_ok, .static_fault_out,
    .static_fault_out_oe, .blink_fault_out, .blink_fault_out_oe, .failsafe_req);
